// >>> hdl/scd_decoder.sv
// sdram command and cke decoder with device state tracking
`timescale 1ns/1ps
`default_nettype none
module scd_decoder (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic cke,
    input wire logic odt,
    input wire logic [scd_pkg::BA_W-1:0] ba,
    input wire logic [scd_pkg::ADDR_W-1:0] addr,
    output logic cmdValid,
    output scd_pkg::scd_cmd_t cmdCode,
    output logic [scd_pkg::BA_W-1:0] cmdBank,
    output logic [scd_pkg::ADDR_W-1:0] cmdAddr,
    output logic autoPrecharge,
    output logic burstChop,
    output logic zqInit,
    output logic [scd_pkg::ADDR_W-1:0] modeReg0,
    output logic [scd_pkg::ADDR_W-1:0] modeReg1,
    output logic [scd_pkg::ADDR_W-1:0] modeReg2,
    output logic [scd_pkg::ADDR_W-1:0] modeReg3,
    output logic [scd_pkg::BANKS-1:0] bankOpen,
    output logic burstActive,
    output logic refreshActive,
    output scd_pkg::scd_pm_t powerMode,
    output scd_pkg::scd_state_t devState,
    output logic allIdle
);
    import scd_pkg::*;

    // ----------------------------------------------------------------
    // reset release and sampled cke history
    // ----------------------------------------------------------------
    logic rstMeta;
    logic rstN;
    logic ckePrev;
    logic [ADDR_W-1:0] modeReg [NUM_MR];
    logic [CNT_W-1:0] burstCnt;
    logic [CNT_W-1:0] prechCnt;
    logic [CNT_W-1:0] refCnt;
    logic [CNT_W-1:0] exitCnt;
    logic burstWrite;
    logic zqSeen;
    logic wakeSync;
    logic inSref;
    scd_cmd_t pinCmd;
    scd_cmd_t next_cmd;
    scd_pm_t next_pm;
    logic [CNT_W-1:0] burstLen;
    logic desOrNop;

    // two flops so reset leaves every domain flop on a clean edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ckePrev <= 1'b0;
        end else begin
            ckePrev <= cke; // cke at edge n-1
        end
    end

    // ----------------------------------------------------------------
    // pin decode
    // ----------------------------------------------------------------
    // strobes plus a10; termination input never enters the decode
    function automatic scd_cmd_t decode_pins(input logic cs, input logic ras,
                                             input logic cas, input logic we,
                                             input logic a10);
        scd_cmd_t c;
        c = CMD_BAD;
        if (cs) begin
            c = CMD_DES;
        end else begin
            case ({ras, cas, we})
                3'b000: c = CMD_MRS;
                3'b001: c = CMD_REF;
                3'b010: c = a10 ? CMD_PREA : CMD_PRE;
                3'b011: c = CMD_ACT;
                3'b100: c = CMD_WR;
                3'b101: c = CMD_RD;
                3'b110: c = a10 ? CMD_ZQCL : CMD_ZQCS;
                3'b111: c = CMD_NOP;
                default: c = CMD_BAD;
            endcase
        end
        return c;
    endfunction

    assign pinCmd = decode_pins(csN, rasN, casN, weN, addr[AP_BIT]);
    assign desOrNop = (pinCmd == CMD_DES) || (pinCmd == CMD_NOP);
    assign inSref = (powerMode == PM_SREF);

    // idle needs every bank shut, no burst, cke high and all timers done
    assign allIdle = (bankOpen == '0) && (burstCnt == '0) && (prechCnt == '0)
                     && (refCnt == '0) && (exitCnt == '0) && cke && ckePrev
                     && (powerMode == PM_NORMAL);

    // fixed length from mode register 0, or a12 when on the fly
    always_comb begin
        burstLen = BL8_CLKS;
        if (modeReg[0][MR0_BL_LSB +: 2] == BL_BC4) begin
            burstLen = BC4_CLKS;
        end else if (modeReg[0][MR0_BL_LSB +: 2] == BL_OTF && !addr[BC_BIT]) begin
            burstLen = BC4_CLKS;
        end
    end

    // ----------------------------------------------------------------
    // command and cke action
    // ----------------------------------------------------------------
    // action chosen from power mode, cke at n-1 and n, and the command
    always_comb begin
        next_cmd = CMD_NOP;
        next_pm = powerMode;
        case (powerMode)
            PM_NORMAL: begin
                if (ckePrev && cke) begin
                    next_cmd = pinCmd;
                end else if (ckePrev && !cke) begin
                    if (pinCmd == CMD_REF && allIdle == 1'b0 && (bankOpen == '0)
                        && burstCnt == '0 && prechCnt == '0 && refCnt == '0
                        && exitCnt == '0) begin
                        next_cmd = CMD_SRE;
                        next_pm = PM_SREF;
                    end else if (desOrNop) begin
                        next_cmd = CMD_PDE;
                        if (burstCnt != '0 || prechCnt != '0) begin
                            next_pm = PM_PD_BUSY;
                        end else if (bankOpen != '0) begin
                            next_pm = PM_PD_ACT;
                        end else begin
                            next_pm = PM_PD_PRE;
                        end
                    end else begin
                        next_cmd = CMD_BAD; // outside the tables
                    end
                end else begin
                    next_cmd = CMD_BAD;
                end
            end
            PM_PD_ACT, PM_PD_PRE, PM_PD_BUSY: begin
                // cke low holds power-down; rising with des or nop leaves
                if (!ckePrev && cke) begin
                    next_cmd = desOrNop ? CMD_PDX : CMD_BAD;
                    if (desOrNop) begin
                        next_pm = PM_NORMAL;
                    end
                end
            end
            PM_SREF: begin
                // exit waits on the clockless wake catch
                if (wakeSync && cke) begin
                    next_cmd = desOrNop ? CMD_SRX : CMD_BAD;
                    if (desOrNop) begin
                        next_pm = PM_NORMAL;
                    end
                end
            end
            default: begin
                next_pm = PM_NORMAL;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            powerMode <= PM_NORMAL;
        end else begin
            powerMode <= next_pm;
        end
    end

    // registered command report; des and nop raise no valid pulse
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            cmdValid <= 1'b0;
            cmdCode <= CMD_NOP;
            cmdBank <= '0;
            cmdAddr <= '0;
            autoPrecharge <= 1'b0;
            burstChop <= 1'b0;
        end else begin
            cmdValid <= (next_cmd != CMD_DES) && (next_cmd != CMD_NOP);
            cmdCode <= next_cmd;
            if (next_cmd != CMD_DES) begin
                cmdBank <= ba;
                cmdAddr <= addr;
            end
            autoPrecharge <= ((next_cmd == CMD_RD) || (next_cmd == CMD_WR)) && addr[AP_BIT];
            burstChop <= ((next_cmd == CMD_RD) || (next_cmd == CMD_WR)) && (burstLen == BC4_CLKS);
        end
    end

    // ----------------------------------------------------------------
    // mode registers and calibration
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MR; gi++) begin : g_mr
            always_ff @(posedge core_clk or negedge rstN) begin
                if (!rstN) begin
                    modeReg[gi] <= MR_RESET;
                end else if (next_cmd == CMD_MRS && ba[1:0] == 2'(gi)) begin
                    modeReg[gi] <= addr;
                end
            end
        end
    endgenerate

    assign modeReg0 = modeReg[0];
    assign modeReg1 = modeReg[1];
    assign modeReg2 = modeReg[2];
    assign modeReg3 = modeReg[3];

    // only the first long calibration after reset is the initial one
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            zqSeen <= 1'b0;
            zqInit <= 1'b0;
        end else if (next_cmd == CMD_ZQCL) begin
            zqSeen <= 1'b1;
            zqInit <= !zqSeen;
        end
    end

    // ----------------------------------------------------------------
    // bank, burst and refresh tracking
    // ----------------------------------------------------------------
    // auto precharge shuts the bank now and lets prechCnt cover the burst
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            bankOpen <= '0;
        end else begin
            case (next_cmd)
                CMD_ACT: bankOpen[ba] <= 1'b1;
                CMD_PRE: bankOpen[ba] <= 1'b0;
                CMD_PREA: bankOpen <= '0;
                CMD_RD, CMD_WR: begin
                    if (addr[AP_BIT]) begin
                        bankOpen[ba] <= 1'b0;
                    end
                end
                default: bankOpen <= bankOpen;
            endcase
        end
    end

    // a new burst may only lengthen the count, never shorten it
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            burstCnt <= '0;
            burstWrite <= 1'b0;
        end else if ((next_cmd == CMD_RD || next_cmd == CMD_WR) && burstLen > burstCnt) begin
            burstCnt <= burstLen;
            burstWrite <= (next_cmd == CMD_WR);
        end else if (burstCnt != '0) begin
            burstCnt <= burstCnt - 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            prechCnt <= '0;
        end else if (next_cmd == CMD_PRE || next_cmd == CMD_PREA) begin
            prechCnt <= RP_CLKS;
        end else if ((next_cmd == CMD_RD || next_cmd == CMD_WR) && addr[AP_BIT]) begin
            prechCnt <= CNT_W'(burstLen + RP_CLKS);
        end else if (prechCnt != '0) begin
            prechCnt <= prechCnt - 5'h01;
        end
    end

    // refresh is only decoded in normal mode, so none starts powered down
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            refCnt <= '0;
        end else if (next_cmd == CMD_REF) begin
            refCnt <= RFC_CLKS;
        end else if (next_cmd == CMD_SRE) begin
            refCnt <= '0;
        end else if (refCnt != '0) begin
            refCnt <= refCnt - 5'h01;
        end
    end

    // exit timer keeps idle low until the exit time has passed
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            exitCnt <= '0;
        end else if (next_cmd == CMD_PDX || next_cmd == CMD_SRX) begin
            exitCnt <= XP_CLKS;
        end else if (exitCnt != '0) begin
            exitCnt <= exitCnt - 5'h01;
        end
    end

    assign burstActive = (burstCnt != '0);
    assign refreshActive = (refCnt != '0);

    // state class from the flags
    always_comb begin
        if (powerMode == PM_SREF) begin
            devState = ST_SREF;
        end else if (powerMode != PM_NORMAL) begin
            devState = ST_PDOWN;
        end else if (burstActive) begin
            devState = burstWrite ? ST_WRITE : ST_READ;
        end else if (prechCnt != '0) begin
            devState = ST_PRECH;
        end else if (refreshActive) begin
            devState = ST_REFR;
        end else if (bankOpen != '0) begin
            devState = ST_ACTIVE;
        end else begin
            devState = ST_IDLE;
        end
    end

    scd_wake_catch u_wake (
        .core_clk(core_clk),
        .rstN(rstN),
        .cke(cke),
        .armed(inSref),
        .wake(wakeSync)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstN);

    mrs_load_a: assert property (next_cmd == CMD_MRS |=>
        modeReg[$past(ba[1:0])] == $past(addr))
        else $error("mode register not loaded");
    des_ignore_a: assert property (powerMode == PM_NORMAL && ckePrev && cke && csN
        |=> !cmdValid && $stable(bankOpen) && $stable(modeReg0))
        else $error("deselect changed state");
    nop_idle_a: assert property (ckePrev && cke && next_cmd == CMD_NOP
        |=> !cmdValid && $stable(bankOpen))
        else $error("nop changed state");
    burst_keep_a: assert property (burstCnt > 5'h01 |=>
        burstCnt >= $past(burstCnt) - 5'h01)
        else $error("burst cut short");
    sref_entry_a: assert property (next_cmd == CMD_SRE |=>
        powerMode == PM_SREF && cmdCode == CMD_SRE && bankOpen == '0)
        else $error("self refresh not entered");
    pd_entry_a: assert property (powerMode == PM_NORMAL && ckePrev && !cke
        && desOrNop && bankOpen != '0 && burstCnt == '0 && prechCnt == '0
        |=> powerMode == PM_PD_ACT)
        else $error("active power-down not entered");
    pd_hold_a: assert property (powerMode != PM_NORMAL && !cke
        |=> powerMode == $past(powerMode))
        else $error("power-down left with cke low");
    no_ref_pd_a: assert property (powerMode != PM_NORMAL
        |=> !(cmdValid && cmdCode == CMD_REF) && refCnt <= $past(refCnt))
        else $error("refresh while powered down");
    idle_def_a: assert property (allIdle |-> bankOpen == '0
        && !burstActive && cke && devState == ST_IDLE)
        else $error("idle with work pending");
    // the bank stays open a second cycle unless the next edge carried a command
    act_open_a: assert property (next_cmd == CMD_ACT |=>
        bankOpen[$past(ba)] && cmdCode == CMD_ACT ##1 (bankOpen[$past(ba, 2)] || cmdValid))
        else $error("activate did not open bank");
    odt_free_a: assert property ($changed(odt) && !csN && ckePrev && cke
        |=> cmdCode == $past(pinCmd))
        else $error("termination changed decode");

    mrs_c: cover property (cmdValid && cmdCode == CMD_MRS);
    sref_c: cover property (powerMode == PM_SREF ##[1:50] cmdCode == CMD_SRX);
    pd_c: cover property (cmdCode == CMD_PDE ##[1:20] cmdCode == CMD_PDX);
    burst_c: cover property (cmdCode == CMD_RD ##1 cmdCode == CMD_WR);
endmodule
`default_nettype wire

// >>> inc/scd_pkg.sv
// shared constants and types for the sdram command decoder
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package scd_pkg;
    // address field widths for the chosen density
    localparam int BA_W = 3;
    localparam int BANKS = 8;
    localparam int ADDR_W = 16;
    localparam int ROW_W = 15;
    localparam int COL_W = 10;
    localparam int NUM_MR = 4;
    // address bit positions
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int MR0_BL_LSB = 0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_BC4 = 2'h2;
    localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;
    // timing: times in ns, tRP, tRFC and tXP counts derived from the 8 ns clock; burst counts fixed
    localparam int CNT_W = 5;
    localparam int CLK_NS = 8;
    localparam int T_RP_NS = 14;
    localparam int T_RFC_NS = 160;
    localparam int T_XP_NS = 24;
    localparam logic [CNT_W-1:0] RP_CLKS = CNT_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RFC_CLKS = CNT_W'((T_RFC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] XP_CLKS = CNT_W'((T_XP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] BL8_CLKS = 5'h04;
    localparam logic [CNT_W-1:0] BC4_CLKS = 5'h02;

    typedef enum logic [3:0] {
        CMD_DES = 4'h0,
        CMD_NOP = 4'h1,
        CMD_MRS = 4'h2,
        CMD_REF = 4'h3,
        CMD_SRE = 4'h4,
        CMD_SRX = 4'h5,
        CMD_PRE = 4'h6,
        CMD_PREA = 4'h7,
        CMD_ACT = 4'h8,
        CMD_WR = 4'h9,
        CMD_RD = 4'hA,
        CMD_ZQCL = 4'hB,
        CMD_ZQCS = 4'hC,
        CMD_PDE = 4'hD,
        CMD_PDX = 4'hE,
        CMD_BAD = 4'hF
    } scd_cmd_t;

    typedef enum logic [2:0] {
        PM_NORMAL = 3'h0,
        PM_PD_ACT = 3'h1,
        PM_PD_PRE = 3'h2,
        PM_PD_BUSY = 3'h3,
        PM_SREF = 3'h4
    } scd_pm_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ACTIVE = 3'h1,
        ST_READ = 3'h2,
        ST_WRITE = 3'h3,
        ST_PRECH = 3'h4,
        ST_REFR = 3'h5,
        ST_PDOWN = 3'h6,
        ST_SREF = 3'h7
    } scd_state_t;
endpackage

// >>> hdl/scd_wake_catch.sv
// clockless catch of cke rising during self refresh, synced to core_clk
`timescale 1ns/1ps
`default_nettype none
module scd_wake_catch (
    input wire logic core_clk,
    input wire logic rstN,
    input wire logic cke,
    input wire logic armed,
    output logic wake
);
    import scd_pkg::*;

    logic caught;
    logic clearN;
    logic syncA;

    // the core clock may be stopped in self refresh, so cke itself clocks
    // the catch flop; it is cleared whenever self refresh is not armed
    assign clearN = armed & rstN;

    // ----------------------------------------------------------------
    // async catch
    // ----------------------------------------------------------------
    always_ff @(posedge cke or negedge clearN) begin
        if (!clearN) begin
            caught <= 1'b0;
        end else begin
            caught <= 1'b1;
        end
    end

    // two-flop synchroniser; syncA feeds only the second flop
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            syncA <= 1'b0;
            wake <= 1'b0;
        end else begin
            syncA <= caught;
            wake <= syncA;
        end
    end
endmodule
`default_nettype wire

// >>> test/scd_ctl_model.sv
// controller model that drives the decoder's command pins
`timescale 1ns/1ps
`default_nettype none
module scd_ctl_model (
    input wire logic core_clk,
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic cke,
    output logic odt,
    output logic [2:0] ba,
    output logic [15:0] addr
);
    // ----------------------------------------
    // request from the scenarios and pin driving
    // ----------------------------------------
    logic [3:0] reqPins = 4'h7;
    logic reqCke = 1'b1;
    logic [2:0] reqBa = 3'h0;
    logic [15:0] reqAddr = 16'h0000;
    logic reqTag = 1'b0;
    logic seenTag = 1'b0;
    logic odtLvl = 1'b0;
    logic [15:0] spin = 16'h0000;
    // one process owns every pin: a fresh request stands for one edge, else
    // no-operation with cke kept and don't-care lines moving
    always @(negedge core_clk) begin
        if (reqTag != seenTag) begin
            seenTag = reqTag;
            {csN, rasN, casN, weN} = reqPins;
            ba = reqBa;
            addr = reqAddr;
            spin = reqAddr;
            odtLvl = ~odtLvl; // toggled so decode can be seen not to follow it
        end else begin
            {csN, rasN, casN, weN} = 4'h7;
            spin = ~spin; // don't-care lines never keep a stale value
            ba = spin[2:0];
            addr = spin;
        end
        cke = reqCke;
        odt = odtLvl;
    end
    // request posted mid-cycle, driven at the next falling edge, then one nop edge
    task automatic issue(input logic [3:0] p, input logic k, input logic [2:0] b,
                         input logic [15:0] a);
        @(posedge core_clk);
        reqPins = p;
        reqCke = k;
        reqBa = b;
        reqAddr = a;
        reqTag = ~reqTag;
        @(negedge core_clk);
        @(negedge core_clk);
    endtask
    // wait cycles hold no-operation while the address lines flip
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// >>> test/sdram_command_cke_decoder_tb_top.sv
// self-checking bench for the command and cke decoder
`timescale 1ns/1ps
`default_nettype none
module sdram_command_cke_decoder_tb_top import scd_pkg::*;;
    // ----------------------------------------
    // pin codes {cs, ras, cas, we}
    // ----------------------------------------
    localparam logic [3:0] P_MRS = 4'h0;
    localparam logic [3:0] P_REF = 4'h1;
    localparam logic [3:0] P_PRE = 4'h2;
    localparam logic [3:0] P_ACT = 4'h3;
    localparam logic [3:0] P_WR = 4'h4;
    localparam logic [3:0] P_RD = 4'h5;
    localparam logic [3:0] P_ZQ = 4'h6;
    localparam logic [3:0] P_NOP = 4'h7;
    localparam logic [3:0] P_DES = 4'h8;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    wire logic csN, rasN, casN, weN, cke, odt;
    wire logic [2:0] ba;
    wire logic [15:0] addr;
    wire logic cmdValid, autoPrecharge, burstChop, zqInit;
    wire logic burstActive, refreshActive, allIdle;
    scd_cmd_t cmdCode;
    scd_pm_t powerMode;
    scd_state_t devState;
    wire logic [2:0] cmdBank;
    wire logic [15:0] cmdAddr;
    wire logic [15:0] mr [4];
    wire logic [7:0] bankOpen;
    int n_errors = 0;
    int compares = 0;
    // ----------------------------------------
    // clock, partner and design
    // ----------------------------------------
    always #4 core_clk = ~core_clk;
    scd_ctl_model ctl (.core_clk(core_clk), .csN(csN), .rasN(rasN), .casN(casN),
        .weN(weN), .cke(cke), .odt(odt), .ba(ba), .addr(addr));
    scd_decoder uut (.core_clk(core_clk), .reset_n(reset_n), .csN(csN), .rasN(rasN),
        .casN(casN), .weN(weN), .cke(cke), .odt(odt), .ba(ba), .addr(addr),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdBank(cmdBank), .cmdAddr(cmdAddr),
        .autoPrecharge(autoPrecharge), .burstChop(burstChop), .zqInit(zqInit),
        .modeReg0(mr[0]), .modeReg1(mr[1]), .modeReg2(mr[2]), .modeReg3(mr[3]),
        .bankOpen(bankOpen), .burstActive(burstActive), .refreshActive(refreshActive),
        .powerMode(powerMode), .devState(devState), .allIdle(allIdle));
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares=%0d errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // all four mode registers, then deselect carrying a load pattern
    task automatic t_mode();
        for (int i = 3; i >= 0; i--) begin
            ctl.issue(P_MRS, 1'b1, 3'(i), (i == 0) ? {14'h0, BL_OTF} : 16'h1230 + 16'(i));
            chk(cmdCode, CMD_MRS);
            chk(mr[i], (i == 0) ? {14'h0, BL_OTF} : 16'h1230 + 16'(i));
        end
        ctl.issue(P_DES & 4'h8, 1'b1, 3'h1, 16'hFFFF);
        chk(cmdValid, 1'b0);
        chk(mr[1], 16'h1231);
        $display("test mode done");
    endtask
    // activate, chopped and full reads, write, single and all precharge
    task automatic t_bank();
        ctl.issue(P_ACT, 1'b1, 3'h2, 16'h0123);
        chk({cmdCode, cmdBank}, {CMD_ACT, 3'h2});
        chk(bankOpen, 8'h04);
        chk(devState, ST_ACTIVE);
        ctl.issue(P_RD, 1'b1, 3'h2, 16'h0008);
        chk({cmdCode, burstChop, autoPrecharge}, {CMD_RD, 2'b10});
        chk({burstActive, devState}, {1'b1, ST_READ});
        ctl.issue(P_RD, 1'b1, 3'h2, 16'h1400);
        chk({cmdCode, burstChop, autoPrecharge}, {CMD_RD, 2'b01});
        ctl.idle(10);
        chk(bankOpen, 8'h00);
        ctl.issue(P_ACT, 1'b1, 3'h5, 16'h0042);
        ctl.issue(P_WR, 1'b1, 3'h5, 16'h1010);
        chk({cmdCode, cmdBank, cmdAddr}, {CMD_WR, 3'h5, 16'h1010});
        chk(devState, ST_WRITE);
        ctl.idle(6);
        ctl.issue(P_PRE, 1'b1, 3'h5, 16'h0000);
        chk({cmdCode, bankOpen}, {CMD_PRE, 8'h00});
        ctl.issue(P_ACT, 1'b1, 3'h1, 16'h0001);
        ctl.issue(P_PRE, 1'b1, 3'h6, 16'h0400);
        chk({cmdCode, bankOpen}, {CMD_PREA, 8'h00});
        $display("test bank done");
    endtask
    // calibration long and short; first long marks initial calibration
    task automatic t_zq();
        ctl.issue(P_ZQ, 1'b1, 3'h0, 16'h0400);
        chk({cmdCode, zqInit}, {CMD_ZQCL, 1'b1});
        ctl.issue(P_ZQ, 1'b1, 3'h0, 16'h0000);
        chk({cmdCode, zqInit}, {CMD_ZQCS, 1'b1});
        ctl.issue(P_ZQ, 1'b1, 3'h0, 16'h0400);
        chk({cmdCode, zqInit}, {CMD_ZQCL, 1'b0});
        $display("test zq done");
    endtask
    // precharge and active power-down, refresh pins ignored while down
    task automatic t_pdown();
        ctl.idle(4);
        chk({allIdle, devState}, {1'b1, ST_IDLE});
        ctl.issue(P_NOP, 1'b0, 3'h0, 16'h0000);
        chk({cmdCode, powerMode}, {CMD_PDE, PM_PD_PRE});
        chk(devState, ST_PDOWN);
        ctl.issue(P_REF, 1'b0, 3'h0, 16'h0000);
        chk({powerMode, refreshActive}, {PM_PD_PRE, 1'b0});
        ctl.issue(P_NOP, 1'b1, 3'h0, 16'h0000);
        chk({cmdCode, powerMode}, {CMD_PDX, PM_NORMAL});
        chk(allIdle, 1'b0);
        ctl.idle(4);
        ctl.issue(P_ACT, 1'b1, 3'h0, 16'h0007);
        ctl.issue(P_DES, 1'b0, 3'h0, 16'h0000);
        chk({cmdCode, powerMode}, {CMD_PDE, PM_PD_ACT});
        ctl.issue(P_DES, 1'b1, 3'h0, 16'h0000);
        chk(powerMode, PM_NORMAL);
        ctl.idle(4);
        ctl.issue(P_PRE, 1'b1, 3'h0, 16'h0400);
        $display("test pdown done");
    endtask
    // refresh, self refresh entry and exit
    task automatic t_sref();
        int k;
        ctl.idle(6);
        ctl.issue(P_REF, 1'b1, 3'h0, 16'h0000);
        chk({cmdCode, refreshActive, devState}, {CMD_REF, 1'b1, ST_REFR});
        ctl.idle(24);
        ctl.issue(P_REF, 1'b0, 3'h0, 16'h0000);
        chk({cmdCode, powerMode}, {CMD_SRE, PM_SREF});
        ctl.idle(3);
        chk({powerMode, devState}, {PM_SREF, ST_SREF});
        ctl.issue(P_NOP, 1'b1, 3'h0, 16'h0000);
        for (k = 0; k < 8 && powerMode !== PM_NORMAL; k++) begin
            @(negedge core_clk);
        end
        if (k == 8) begin
            n_errors++;
            wrap_up();
        end
        chk(cmdCode, CMD_SRX);
        $display("test sref done");
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1; // held high from here on
        ctl.idle(4);
        chk(mr[2], MR_RESET); // reset value of a mode register
        t_mode();
        t_bank();
        t_zq();
        t_pdown();
        t_sref();
        wrap_up();
    end
endmodule
`default_nettype wire
